/* File: hw/ddrtc_ctrl.sv */
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module ddrtc_ctrl #(
  parameter int CK_DIV = 2
) (
  // System
  input  logic        clk,
  input  logic        reset,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic        pready,
  output logic [31:0] prdata,
  output logic        pslverr,
  // Memory pins
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  ba,
  output logic [13:0] addr,
  output logic        odt,
  output logic        dqs_out,
  output logic        dqs_oe
);
  import ddrtc_pkg::*;
  typedef ddrtc_cnt_t cnt_t;
  localparam int TCK = CLK_PS * CK_DIV;

  function automatic cnt_t cu(input int ps);
    return cnt_t'(cyc_up(ps, TCK));
  endfunction
  function automatic logic ok(input cnt_t x);
    return x <= cnt_t'(1);
  endfunction
  function automatic cnt_t mx(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction

  // Picosecond figures rounded up to link cycles; the tRAS limit and refresh intervals round down
  localparam cnt_t RAS_S = cu(T_RAS_S_PS);
  localparam cnt_t RAS_F = cu(T_RAS_F_PS);
  localparam cnt_t RAS_LIM = cnt_t'(cyc_dn(T_RAS_MAX_PS, TCK) - RAS_GUARD);
  localparam cnt_t RC_S = cu(T_RC_S_PS);
  localparam cnt_t RC_F = cu(T_RC_F_PS);
  localparam cnt_t RFC = cu(T_RFC_PS);
  localparam cnt_t XSNR = cu(T_RFC_PS + T_XSNR_ADD_PS);
  localparam cnt_t RCD = cu(T_RCD_PS);
  localparam cnt_t RP = cu(T_RP_PS);
  localparam cnt_t WRC = cu(T_WR_PS);
  localparam cnt_t RRD1 = cu(T_RRD_1K_PS);
  localparam cnt_t RRD2 = cu(T_RRD_2K_PS);
  localparam cnt_t WTR_S = mx(cu(T_WTR_S_PS), cnt_t'(WTR_MIN_C));
  localparam cnt_t WTR_F = mx(cu(T_WTR_F_PS), cnt_t'(WTR_MIN_C));
  localparam cnt_t RTP = cu(T_RTP_PS);
  localparam cnt_t REFI = cnt_t'(cyc_dn(T_REFI_PS, TCK));
  localparam cnt_t REFI_H = cnt_t'(cyc_dn(T_REFI_HOT_PS, TCK));
  localparam cnt_t BLH = cnt_t'(BL_HALF);
  localparam logic [3:0] HALF = 4'(CK_DIV / 2);
  localparam logic [3:0] LAST = 4'(CK_DIV - 1);
  localparam int MRD_A = MRD_C - 1;
  localparam int CCD_A = CCD_C - 1;
  localparam int CKE_A = CKE_C - 1;
  localparam int ANPD_A = ANPD_C - 1;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic       tick;
  assign tick = (phase == LAST);
  assign next_phase = tick ? 4'h0 : phase + 4'h1;

  // Commands change at the falling edge, so they sit centred on the rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= 4'h0;
      ck    <= 1'b0;
    end else begin
      phase <= next_phase;
      ck    <= (next_phase >= HALF);
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic        pend, err, fast, page2k, hot, sr, pd_open, slow_exit;
  ddrtc_op_t   sw_op;
  logic [1:0]  sw_ba;
  logic [13:0] sw_addr;
  logic [2:0]  cl, al, wrm;
  logic [3:0]  owed, open;
  logic        acc, sw_take, sw_drop, issue;
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign pslverr = acc & (paddr != REG_CMD) & (paddr != REG_CFG) & (paddr != REG_STAT);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend    <= 1'b0;
      sw_op   <= OP_NOP;
      sw_ba   <= 2'h0;
      sw_addr <= 14'h0000;
    end else if (sw_take) begin
      pend <= 1'b0;
    end else if (acc && pwrite && paddr == REG_CMD && !pend) begin
      pend    <= 1'b1;
      sw_op   <= ddrtc_op_t'(pwdata[CMD_OP_LSB +: 4]);
      sw_ba   <= pwdata[CMD_BA_LSB +: 2];
      sw_addr <= pwdata[CMD_ADDR_LSB +: 14];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fast   <= 1'b0;
      page2k <= 1'b0;
      hot    <= 1'b0;
      err    <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == REG_CFG) begin
        fast   <= pwdata[CFG_FAST];
        page2k <= pwdata[CFG_PAGE2K];
        hot    <= pwdata[CFG_HOT];
      end
      // A drop in the same cycle as the clear keeps the flag
      if (sw_drop)
        err <= 1'b1;
      else if (acc && pwrite && paddr == REG_STAT)
        err <= 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == REG_CMD)
        prdata <= {2'h0, sw_addr, 10'h000, sw_ba, sw_op};
      else if (paddr == REG_CFG)
        prdata <= {29'h0, hot, page2k, fast};
      else if (paddr == REG_STAT)
        prdata <= {16'h0, err, odt, sr, cke, open, owed, 3'h0, pend};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  cnt_t rc_c [4];
  cnt_t rcd_c[4];
  cnt_t pre_c[4];
  cnt_t act_c[4];
  cnt_t age  [4];
  cnt_t mrd, rrd, ccd, wtr, rfc, xp, xrd, cke_c, odt_c, axp, wcnt, refi;
  cnt_t next_wcnt, wl;
  ddrtc_op_t op;
  logic [1:0]  ob;
  logic [13:0] oa;
  logic from_sw, st, tm, urgent;
  assign wl = cnt_t'(al) + cnt_t'(cl) - cnt_t'(1);
  assign urgent = owed >= 4'(OWED_MAX - 1);

  // Housekeeping first: overdue rows, refresh once OWED_MAX - 1 are owed, then software
  always_comb begin
    op = OP_NOP;
    ob = sw_ba;
    oa = sw_addr;
    from_sw = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (open[b] && age[b] >= RAS_LIM && op == OP_NOP) begin
        op = cke ? OP_PRE : OP_PDX;
        ob = 2'(b);
      end
    end
    if (op != OP_NOP) begin
      oa = 14'h0000;
    end else if (urgent && !sr) begin
      oa = 14'h0000;
      if (!cke)
        op = OP_PDX;
      else
        op = (|open) ? OP_PREA : OP_REF;
    end else if (pend) begin
      op = sw_op;
      from_sw = 1'b1;
    end
  end

  // Structure in st, spacing in tm
  always_comb begin
    logic base;
    logic allpre, allrc, closed;
    base = cke && ok(mrd) && ok(xp);
    allpre = 1'b1;
    allrc = 1'b1;
    for (int b = 0; b < 4; b++) begin
      allpre &= ok(pre_c[b]);
      allrc &= ok(rc_c[b]);
    end
    closed = ~|open;
    st = 1'b0;
    tm = 1'b0;
    case (op)
      OP_NOP: begin
        st = 1'b1;
        tm = 1'b1;
      end
      OP_MRS: begin
        st = cke && closed;
        tm = base;
      end
      OP_ACT: begin
        st = cke && !open[ob];
        tm = base && ok(rc_c[ob]) && ok(act_c[ob]) && ok(rrd) && ok(rfc);
      end
      OP_RD, OP_RDA: begin
        st = cke && open[ob];
        tm = base && ok(rcd_c[ob]) && ok(ccd) && ok(wtr) && ok(xrd);
      end
      OP_WR, OP_WRA: begin
        st = cke && open[ob];
        tm = base && ok(rcd_c[ob]) && ok(ccd) && wcnt == '0;
      end
      OP_PRE: begin
        st = cke;
        tm = base && ok(pre_c[ob]);
      end
      OP_PREA: begin
        st = cke;
        tm = base && allpre;
      end
      OP_REF: begin
        st = cke && closed;
        tm = base && ok(rfc) && allrc;
      end
      OP_PDE, OP_SRE: begin
        st = cke && (op == OP_PDE || closed);
        tm = base && ok(cke_c) && ok(odt_c) && ok(wtr) && ok(rfc) && wcnt == '0;
      end
      OP_PDX, OP_SRX: begin
        st = !cke && (sr == (op == OP_SRX));
        tm = ok(cke_c);
      end
      default: begin
        st = cke;
        tm = ok(axp);
      end
    endcase
  end

  assign issue = tick && st && tm && op != OP_NOP;
  assign sw_take = tick && from_sw && (!st || tm);
  assign sw_drop = tick && from_sw && !st;

  // Per-bank timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      open <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        rc_c[b] <= '0;
        rcd_c[b] <= '0;
        pre_c[b] <= '0;
        act_c[b] <= '0;
        age[b] <= '0;
      end
    end else if (tick) begin
      for (int b = 0; b < 4; b++) begin
        if (rc_c[b] != '0) rc_c[b] <= rc_c[b] - cnt_t'(1);
        if (rcd_c[b] != '0) rcd_c[b] <= rcd_c[b] - cnt_t'(1);
        if (pre_c[b] != '0) pre_c[b] <= pre_c[b] - cnt_t'(1);
        if (act_c[b] != '0) act_c[b] <= act_c[b] - cnt_t'(1);
        if (open[b] && age[b] != '1) age[b] <= age[b] + cnt_t'(1);
        if (issue && op == OP_PREA && open[b]) act_c[b] <= RP;
      end
      if (issue) begin
        case (op)
          OP_ACT: begin
            open[ob] <= 1'b1;
            rc_c[ob] <= fast ? RC_F : RC_S;
            rcd_c[ob] <= RCD;
            pre_c[ob] <= fast ? RAS_F : RAS_S;
            age[ob] <= '0;
          end
          OP_RD: pre_c[ob] <= mx(pre_c[ob], cnt_t'(al) + RTP);
          OP_RDA: begin
            open[ob] <= 1'b0;
            act_c[ob] <= mx(pre_c[ob], cnt_t'(al) + RTP) + RP;
          end
          OP_WR: pre_c[ob] <= mx(pre_c[ob], wl + BLH + WRC);
          OP_WRA: begin
            open[ob] <= 1'b0;
            act_c[ob] <= wl + BLH + mx(cnt_t'(wrm) + cnt_t'(1), WRC) + RP;
          end
          OP_PRE: begin
            open[ob] <= 1'b0;
            if (open[ob]) act_c[ob] <= RP;
          end
          OP_PREA: open <= 4'h0;
          default: open <= open;
        endcase
      end
    end
  end

  // Shared timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {mrd, rrd, ccd, wtr, rfc, xp, xrd, cke_c, odt_c, axp} <= '0;
    end else if (tick) begin
      if (mrd != '0) mrd <= mrd - cnt_t'(1);
      if (rrd != '0) rrd <= rrd - cnt_t'(1);
      if (ccd != '0) ccd <= ccd - cnt_t'(1);
      if (wtr != '0) wtr <= wtr - cnt_t'(1);
      if (rfc != '0) rfc <= rfc - cnt_t'(1);
      if (xp != '0) xp <= xp - cnt_t'(1);
      if (xrd != '0) xrd <= xrd - cnt_t'(1);
      if (cke_c != '0) cke_c <= cke_c - cnt_t'(1);
      if (odt_c != '0) odt_c <= odt_c - cnt_t'(1);
      if (axp != '0) axp <= axp - cnt_t'(1);
      if (issue) begin
        case (op)
          OP_MRS: mrd <= cnt_t'(MRD_C);
          OP_ACT: rrd <= page2k ? RRD2 : RRD1;
          OP_RD, OP_RDA: ccd <= cnt_t'(CCD_C);
          OP_WR, OP_WRA: begin
            ccd <= cnt_t'(CCD_C);
            wtr <= wl + BLH + (fast ? WTR_F : WTR_S);
          end
          OP_REF: rfc <= RFC;
          OP_PDE, OP_SRE: cke_c <= cnt_t'(CKE_C);
          OP_PDX: begin
            cke_c <= cnt_t'(CKE_C);
            xp <= pd_open ? cnt_t'(XARD_C) : cnt_t'(XP_C);
            xrd <= (pd_open && slow_exit) ? cnt_t'(XARDS_C) - cnt_t'(al) : '0;
            axp <= cnt_t'(AXPD_C);
          end
          OP_SRX: begin
            cke_c <= cnt_t'(CKE_C);
            xp <= XSNR;
            xrd <= cnt_t'(XSRD_C);
            axp <= cnt_t'(AXPD_C);
          end
          OP_ODT1, OP_ODT0: odt_c <= cnt_t'(ANPD_C);
          default: mrd <= mrd;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode, power and refresh state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cke <= 1'b1;
      sr <= 1'b0;
      pd_open <= 1'b0;
      odt <= 1'b0;
      cl <= CL_RST;
      al <= 3'h0;
      wrm <= WRM_RST;
      slow_exit <= 1'b0;
    end else if (issue) begin
      case (op)
        OP_MRS: begin
          if (ob == 2'h0) begin
            slow_exit <= oa[MR_SLOW_BIT];
            cl <= oa[MR_CL_LSB +: 3];
            wrm <= oa[MR_WR_LSB +: 3];
          end else if (ob == 2'h1) begin
            al <= oa[EMR_AL_LSB +: 3];
          end
        end
        OP_PDE: begin
          cke <= 1'b0;
          pd_open <= |open;
        end
        OP_SRE: begin
          cke <= 1'b0;
          sr <= 1'b1;
        end
        OP_PDX: cke <= 1'b1;
        OP_SRX: begin
          cke <= 1'b1;
          sr <= 1'b0;
        end
        OP_ODT1: odt <= 1'b1;
        OP_ODT0: odt <= 1'b0;
        default: cke <= cke;
      endcase
    end
  end

  // No refresh is owed while the device refreshes itself
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refi <= '0;
      owed <= 4'h0;
    end else if (tick) begin
      logic hit, paid;
      hit = (refi >= (hot ? REFI_H : REFI) - cnt_t'(1));
      paid = issue && (op == OP_REF || op == OP_SRE);
      refi <= (hit || sr) ? '0 : refi + cnt_t'(1);
      if (paid)
        owed <= (op == OP_SRE) ? 4'h0 : owed - 4'h1 + 4'(hit && !sr);
      else if (hit && !sr && owed < 4'(OWED_MAX))
        owed <= owed + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Command pins and write strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= PC_NOP;
      ba <= 2'h0;
      addr <= 14'h0000;
    end else if (tick) begin
      logic [2:0] pc;
      case (op)
        OP_MRS: pc = PC_MRS;
        OP_ACT: pc = PC_ACT;
        OP_RD, OP_RDA: pc = PC_RD;
        OP_WR, OP_WRA: pc = PC_WR;
        OP_PRE, OP_PREA: pc = PC_PRE;
        OP_REF, OP_SRE: pc = PC_REF;
        default: pc = PC_NOP;
      endcase
      cs_n <= !(issue && pc != PC_NOP);
      {ras_n, cas_n, we_n} <= issue ? pc : PC_NOP;
      ba <= ob;
      addr <= oa;
      if (op == OP_RDA || op == OP_WRA || op == OP_PREA)
        addr[A10_BIT] <= 1'b1;
      else if (op != OP_MRS && op != OP_ACT)
        addr[A10_BIT] <= 1'b0;
    end
  end

  // Writes wait for the strobe window to drain; costs bus rate, saves logic
  always_comb begin
    next_wcnt = wcnt;
    if (tick && issue && (op == OP_WR || op == OP_WRA))
      next_wcnt = wl + BLH;
    else if (tick && wcnt != '0)
      next_wcnt = wcnt - cnt_t'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wcnt <= '0;
      dqs_oe <= 1'b0;
      dqs_out <= 1'b0;
    end else begin
      wcnt <= next_wcnt;
      dqs_oe <= next_wcnt != '0 && next_wcnt <= BLH + cnt_t'(1);
      dqs_out <= next_wcnt != '0 && next_wcnt <= BLH && next_phase >= HALF;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cnt_t gap, cke_age, odt_age;
  ddrtc_op_t last_op;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap <= '1;
      cke_age <= '1;
      odt_age <= '1;
      last_op <= OP_NOP;
    end else if (tick) begin
      gap <= issue ? '0 : (gap == '1 ? gap : gap + cnt_t'(1));
      if (issue) last_op <= op;
      cke_age <= cke_age == '1 ? cke_age : cke_age + cnt_t'(1);
      odt_age <= odt_age == '1 ? odt_age : odt_age + cnt_t'(1);
      if (issue && op inside {OP_PDE, OP_PDX, OP_SRE, OP_SRX}) cke_age <= '0;
      if (issue && op inside {OP_ODT1, OP_ODT0}) odt_age <= '0;
    end
  end

  default clocking dflt @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_wr_issue;
    issue && (op == OP_WR || op == OP_WRA);
  endsequence
  sequence s_preamble;
    $rose(dqs_oe) && !dqs_out;
  endsequence

  AST_MRS_GAP: assert property (issue && last_op == OP_MRS |-> gap >= cnt_t'(MRD_A))
    else $error("mode set gap too short");
  AST_RRD: assert property (issue && op == OP_ACT && last_op == OP_ACT
      |-> gap >= (page2k ? RRD2 : RRD1) - cnt_t'(1))
    else $error("activate gap too short");
  AST_RFC: assert property (issue && last_op == OP_REF |-> gap >= RFC - cnt_t'(1))
    else $error("refresh cycle violated");
  AST_CCD: assert property (issue && op inside {OP_RD, OP_RDA, OP_WR, OP_WRA}
      && last_op inside {OP_RD, OP_RDA, OP_WR, OP_WRA} |-> gap >= cnt_t'(CCD_A))
    else $error("column gap too short");
  AST_CKE_PULSE: assert property ($changed(cke) |-> $past(cke_age) >= cnt_t'(CKE_A))
    else $error("clock enable pulse too short");
  AST_OWED: assert property (owed <= 4'(OWED_MAX))
    else $error("too many refreshes owed");
  AST_ODT_PD: assert property ($fell(cke) |-> $past(odt_age) >= cnt_t'(ANPD_A))
    else $error("termination not settled before power-down");
  AST_RAS_MAX: assert property (open[0] |-> age[0] < RAS_LIM + cnt_t'(RAS_GUARD))
    else $error("row held open too long");
  AST_DQS_PRE: assert property (s_wr_issue |-> ##[1:40] s_preamble ##[1:4] $rose(dqs_out))
    else $error("write strobe missing");
endmodule

/* File: hw/ddrtc_pkg.sv */
package ddrtc_pkg;
  typedef logic [9:0] ddrtc_cnt_t;
  typedef enum logic [3:0] {
    OP_NOP, OP_MRS, OP_ACT, OP_RD, OP_RDA, OP_WR, OP_WRA, OP_PRE,
    OP_PREA, OP_REF, OP_PDE, OP_PDX, OP_SRE, OP_SRX, OP_ODT1, OP_ODT0
  } ddrtc_op_t;

  // ----------------------------------------------------------------
  // Timing in picoseconds
  // ----------------------------------------------------------------
  localparam int CLK_PS        = 100000;
  localparam int T_RAS_S_PS    = 40000;
  localparam int T_RAS_F_PS    = 45000;
  localparam int T_RAS_MAX_PS  = 70000000;
  localparam int T_RC_S_PS     = 55000;
  localparam int T_RC_F_PS     = 60000;
  localparam int T_RFC_PS      = 105000;
  localparam int T_XSNR_ADD_PS = 10000;
  localparam int T_RCD_PS      = 15000;
  localparam int T_RP_PS       = 15000;
  localparam int T_WR_PS       = 15000;
  localparam int T_RRD_1K_PS   = 7500;
  localparam int T_RRD_2K_PS   = 10000;
  localparam int T_WTR_S_PS    = 10000;
  localparam int T_WTR_F_PS    = 7500;
  localparam int T_RTP_PS      = 7500;
  localparam int T_REFI_PS     = 7800000;
  localparam int T_REFI_HOT_PS = 3900000;

  // ----------------------------------------------------------------
  // Timing in link clock cycles
  // ----------------------------------------------------------------
  localparam int MRD_C     = 2;
  localparam int CCD_C     = 2;
  localparam int XARD_C    = 2;
  localparam int XARDS_C   = 6;
  localparam int XP_C      = 2;
  localparam int XSRD_C    = 200;
  localparam int CKE_C     = 3;
  localparam int WTR_MIN_C = 2;
  localparam int ANPD_C    = 3;
  localparam int AXPD_C    = 8;
  localparam int OWED_MAX  = 8;
  localparam int BL_HALF   = 2;
  localparam int RAS_GUARD = 16;

  function automatic int cyc_up(input int ps, input int tck);
    int c;
    c = (ps + tck - 1) / tck;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ps, input int tck);
    int c;
    c = ps / tck;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_CFG  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BA_LSB   = 4;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CFG_FAST     = 0;
  localparam int CFG_PAGE2K   = 1;
  localparam int CFG_HOT      = 2;
  localparam int MR_CL_LSB    = 4;
  localparam int MR_WR_LSB    = 9;
  localparam int MR_SLOW_BIT  = 12;
  localparam int EMR_AL_LSB   = 3;
  localparam int A10_BIT      = 10;
  localparam logic [2:0] CL_RST  = 3'h3;
  localparam logic [2:0] WRM_RST = 3'h2;
  // Pin codes on ras_n, cas_n, we_n
  localparam logic [2:0] PC_MRS = 3'h0;
  localparam logic [2:0] PC_REF = 3'h1;
  localparam logic [2:0] PC_PRE = 3'h2;
  localparam logic [2:0] PC_ACT = 3'h3;
  localparam logic [2:0] PC_WR  = 3'h4;
  localparam logic [2:0] PC_RD  = 3'h5;
  localparam logic [2:0] PC_NOP = 3'h7;
endpackage

/* File: verif/ddrtc_dev_model.sv */
`timescale 1ns/1ps
module ddrtc_dev_model (
  // Pins from the controller
  input  wire logic ck,
  input  wire logic cke,
  input  wire logic cs_n,
  input  wire logic ras_n,
  input  wire logic cas_n,
  input  wire logic we_n,
  input  wire logic odt,
  // Seen by the bench
  output logic [7:0] viol,
  output logic       term_on
);
  int cyc = 0, t_mrs = -9, t_col = -9, t_cke = 0;
  logic cke_q = 1'b1;
  logic [2:0] odt_sh = 3'h0;
  wire [2:0] code = {ras_n, cas_n, we_n};
  initial viol = 8'h00;
  initial term_on = 1'b0;
  // Faults are counted, not stopped, so one run shows them all
  always @(posedge ck) begin
    cyc <= cyc + 1;
    odt_sh <= {odt_sh[1:0], odt};
    if (!cs_n && cke && code != 3'h7) begin
      if (cyc - t_mrs < 2) viol <= viol + 8'h01;
      if (code == 3'h0) t_mrs <= cyc;
      if (code[2:1] == 2'b10 && cyc - t_col < 2) viol <= viol + 8'h01;
      if (code[2:1] == 2'b10) t_col <= cyc;
    end
    if (cke !== cke_q) begin
      if (cyc - t_cke < 3) viol <= viol + 8'h01;
      t_cke <= cyc;
      cke_q <= cke;
    end
  end
  // On after two cycles, off after two and a half
  always @(ck) begin
    if (ck && odt_sh[1]) term_on <= 1'b1;
    else if (!ck && !odt_sh[2]) term_on <= 1'b0;
  end
endmodule

/* File: verif/ddr2_command_timing_rules_bench.sv */
`timescale 1ns/1ps
module ddr2_command_timing_rules_bench;
  import ddrtc_pkg::*;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, cke_q = 1;
  logic        pready, pslverr, ck, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_out, dqs_oe;
  logic        term_on, err_seen, pre_a10;
  logic [7:0]  paddr = 8'h00, viol;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  ba;
  logic [13:0] addr;
  logic [4:0]  last_pin;
  int          n_mismatch = 0, compares = 0, ckc = 0, t_up = 0, t_rd = 0, n_ref = 0;

  always #50 clk = ~clk;

  ddrtc_ctrl #(.CK_DIV(2)) dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt,
    .dqs_out, .dqs_oe);
  ddrtc_dev_model mem_u (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .viol, .term_on);

  // Commands as the device takes them, on rising ck
  always @(posedge ck) begin
    ckc <= ckc + 1;
    cke_q <= cke;
    if (cke && !cke_q) t_up <= ckc;
    if (!cs_n && cke) last_pin <= {ras_n, cas_n, we_n, ba};
    if (!cs_n && cke && {ras_n, cas_n, we_n} == PC_RD) t_rd <= ckc;
    if (!cs_n && cke && {ras_n, cas_n, we_n} == PC_REF) n_ref <= n_ref + 1;
    if (!cs_n && cke && {ras_n, cas_n, we_n} == PC_PRE) pre_a10 <= addr[A10_BIT];
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat;
    apb(1'b0, REG_STAT, 32'h0);
  endtask

  // Returns once the command is sent or dropped, or after 60 status polls
  task automatic cmd(input logic [3:0] op, input logic [1:0] b, input logic [13:0] a);
    int n = 0;
    apb(1'b1, REG_CMD, {2'h0, a, 10'h0, b, op});
    do stat(); while (rd[0] !== 1'b0 && ++n < 60);
  endtask

  task automatic t_regs;
    stat();
    chk("stat", 32'h0000_1000, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_seen});
    apb(1'b1, REG_CFG, 32'h7);
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg", 32'h7, rd);
    apb(1'b1, REG_CFG, 32'h0);
    cmd(OP_RD, 2'h3, 14'h0);
    stat();
    chk("dropped", 32'h1, {31'h0, rd[15]});
    apb(1'b1, REG_STAT, 32'h0);
    stat();
    chk("cleared", 32'h0, {31'h0, rd[15]});
  endtask

  task automatic t_rw;
    int n = 0;
    logic q = 1'b0;
    cmd(OP_ACT, 2'h1, 14'h0);
    chk("act", {27'h0, PC_ACT, 2'h1}, {27'h0, last_pin});
    cmd(OP_ACT, 2'h2, 14'h0);
    stat();
    chk("open", 32'h6, {28'h0, rd[11:8]});
    cmd(OP_RD, 2'h1, 14'h0);
    cmd(OP_WR, 2'h1, 14'h0);
    repeat (40) begin
      @(posedge clk);
      if (dqs_oe && dqs_out && !q) n++;
      q = dqs_out;
    end
    chk("strobes", 32'h2, n);
  endtask

  // Slow exit chosen, so the read must lag the exit
  task automatic t_pd;
    cmd(OP_PREA, 2'h0, 14'h0400);
    chk("pre all", 32'h1, {31'h0, pre_a10});
    cmd(OP_MRS, 2'h0, 14'h1430);
    cmd(OP_ACT, 2'h0, 14'h0);
    cmd(OP_PDE, 2'h0, 14'h0);
    cmd(OP_PDX, 2'h0, 14'h0);
    cmd(OP_RD, 2'h0, 14'h0);
    chk("exit", 32'h1, {31'h0, t_rd - t_up >= XARDS_C});
  endtask

  task automatic t_ref;
    int r0;
    cmd(OP_PREA, 2'h0, 14'h0400);
    cmd(OP_ODT1, 2'h0, 14'h0);
    r0 = n_ref;
    repeat (1200) @(posedge clk);
    chk("term on", 32'h1, {31'h0, term_on});
    stat();
    chk("owed", 32'h1, {31'h0, rd[7:4] <= 4'h8});
    chk("refs", 32'h1, {31'h0, n_ref - r0 >= 7});
    cmd(OP_ODT0, 2'h0, 14'h0);
    repeat (8) @(posedge clk);
    chk("term off", 32'h0, {31'h0, term_on});
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_rw();
    t_pd();
    t_ref();
    chk("faults", 32'h0, {24'h0, viol});
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
